//--- logic/bfs_supervisor.sv
`timescale 1ns/1ps
module bfs_supervisor
  import bfs_pkg::*;
(
  input  wire logic             hclk,            // bus and filter clock
  input  wire logic             hresetn,         // async reset, active low
  input  wire logic             hsel,            // ahb slave select
  input  wire logic [31:0]      haddr,           // ahb address
  input  wire logic [1:0]       htrans,          // ahb transfer type
  input  wire logic             hwrite,          // ahb write
  input  wire logic [2:0]       hsize,           // ahb size
  input  wire logic             hready,          // ahb bus ready
  input  wire logic [31:0]      hwdata,          // ahb write data
  output logic                  hreadyout,       // ahb slave ready
  output logic      [31:0]      hrdata,          // ahb read data
  output logic                  hresp,           // ahb response
  input  wire bfs_pkg::bfs_cmp_t cmp_in,         // analog comparators
  input  wire bfs_pkg::bfs_cmd_t leg_cmd,        // leg command pins
  input  wire logic             wake_pin,        // wake pin
  input  wire logic             inhibit_pin,     // inhibit pin
  input  wire logic             inhibit_float,   // inhibit pin open
  output bfs_pkg::bfs_leg_t     bridge_leg_a,    // leg a switch drive
  output bfs_pkg::bfs_leg_t     bridge_leg_b,    // leg b switch drive
  output logic                  fault_status_n   // fault status, active low
);
  import bfs_pkg::*;

  localparam logic [CNT_W-1:0] FLT_LEN [N_FLT] =
    '{UV_FILT_CYC, UV_FILT_CYC, OV_FILT_CYC, OT_FILT_CYC};

  // synchroniser
  bfs_cmp_t             sync1_q;
  bfs_cmp_t             sync2_q;

  // filters
  logic [N_FLT-1:0]     flt_in;
  logic [N_FLT-1:0]     flt_done;

  // protection state
  logic [ST_W-1:0]      status_q;
  logic [ST_W-1:0]      status_d;
  logic                 uv_lock_q;
  logic                 uv_lock_d;
  logic                 ov_act_q;
  logic                 ov_act_d;
  logic                 wake_prev_q;
  logic                 inh_prev_q;

  // registers
  logic [15:0]          mask_q;
  logic [15:0]          mask_d;
  logic [15:0]          config_q;
  logic [15:0]          config_d;

  // bus
  logic                 wr_pend_q;
  logic                 wr_pend_d;
  logic [7:0]           wr_addr_q;
  logic [7:0]           wr_addr_d;
  logic [31:0]          hrdata_d;
  logic                 take;

  // outputs
  bfs_leg_t             leg_a_d;
  bfs_leg_t             leg_b_d;
  logic                 fsn_d;

  // combinational helpers
  logic                 clr_op;
  logic [ST_W-1:0]      clr_bits;
  logic                 toggle;
  logic                 hmode;
  logic                 en_ok;
  logic                 inhibited;
  logic                 cmd_a;
  logic                 cmd_b;
  logic                 a_float;
  logic                 b_float;
  logic                 sc_a;
  logic                 sc_b;
  logic                 ov_force;
  bfs_drv_t             drv_a;
  bfs_drv_t             drv_b;

  // comparators are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= cmp_in;
      sync2_q <= sync1_q;
    end
  end

  assign flt_in[FLT_UV]    = sync2_q.uv;
  assign flt_in[FLT_UVREC] = sync2_q.uv_rec & uv_lock_q;
  assign flt_in[FLT_OV]    = sync2_q.ov;
  assign flt_in[FLT_OT]    = sync2_q.ot;

  genvar gi;
  generate
    for (gi = 0; gi < N_FLT; gi++)
    begin : g_flt
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;

      always_comb
      begin
        if (!flt_in[gi])
          cnt_d = '0;
        else if (cnt_q == FLT_LEN[gi])
          cnt_d = cnt_q;
        else
          cnt_d = cnt_q + 1'b1;
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          cnt_q <= '0;
        else
          cnt_q <= cnt_d;
      end

      assign flt_done[gi] = flt_in[gi] && (cnt_q == FLT_LEN[gi]);
    end
  endgenerate

  // bus write and fault-clear decode
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ ||
                                   htrans == HTRANS_SEQ);

  always_comb
  begin
    clr_op   = wr_pend_q && (wr_addr_q == REG_CLEAR);
    clr_bits = clr_op ? hwdata[ST_W-1:0] & STATUS_W1C : '0;
    // a pin edge counts as a full clear
    toggle   = (wake_pin != wake_prev_q) || (inhibit_pin != inh_prev_q);
    if (toggle)
      clr_bits = STATUS_W1C;
    // overtemperature latch holds while still hot
    if (sync2_q.ot_hys)
      clr_bits[ST_OT] = 1'b0;
  end

  // fault state
  always_comb
  begin
    uv_lock_d = uv_lock_q;
    if (flt_done[FLT_UV])
      uv_lock_d = 1'b1;
    else if (flt_done[FLT_UVREC])
      uv_lock_d = 1'b0;

    ov_act_d = ov_act_q;
    if (flt_done[FLT_OV])
      ov_act_d = 1'b1;
    else if (!sync2_q.ov)
      ov_act_d = 1'b0;

    // clear first, then sets so a same-cycle event wins
    status_d = status_q & ~clr_bits;
    if (uv_lock_d)
      status_d[ST_UV] = 1'b1;
    if (ov_act_d)
      status_d[ST_OV] = 1'b1;
    if (flt_done[FLT_OT])
      status_d[ST_OT] = 1'b1;
    status_d[ST_SCG1] = status_d[ST_SCG1] | sync2_q.sc[0];
    status_d[ST_SCG2] = status_d[ST_SCG2] | sync2_q.sc[1];
    status_d[ST_SCP1] = status_d[ST_SCP1] | sync2_q.sc[2];
    status_d[ST_SCP2] = status_d[ST_SCP2] | sync2_q.sc[3];
    status_d[ST_TW]   = sync2_q.tw;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uv_lock_q   <= 1'b0;
      ov_act_q    <= 1'b0;
      status_q    <= '0;
      // awake is the idle level, so no false toggle after reset
      wake_prev_q <= 1'b1;
      inh_prev_q  <= 1'b0;
    end
    else
    begin
      uv_lock_q   <= uv_lock_d;
      ov_act_q    <= ov_act_d;
      status_q    <= status_d;
      wake_prev_q <= wake_pin;
      inh_prev_q  <= inhibit_pin;
    end
  end

  // register file; zero wait states, data phase write
  always_comb
  begin
    wr_pend_d = take && hwrite;
    wr_addr_d = take ? haddr[7:0] : wr_addr_q;
    mask_d    = mask_q;
    config_d  = config_q;
    if (wr_pend_q && wr_addr_q == REG_MASK)
      mask_d = (mask_q & ~MASK_WR) | (hwdata[15:0] & MASK_WR);
    if (wr_pend_q && wr_addr_q == REG_CONFIG)
      config_d = (config_q & ~CONFIG_WR) | (hwdata[15:0] & CONFIG_WR);
    hrdata_d = '0;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        REG_STATUS: hrdata_d = {16'h0000, status_q};
        REG_MASK:   hrdata_d = {16'h0000, mask_q};
        REG_CONFIG: hrdata_d = {16'h0000, config_q};
        default:    hrdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      mask_q    <= MASK_RST;
      config_q  <= CONFIG_RST;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      mask_q    <= mask_d;
      config_q  <= config_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // leg control
  always_comb
  begin
    hmode     = config_q[CF_MODE];
    inhibited = inhibit_pin | inhibit_float;
    en_ok     = wake_pin & config_q[CF_EN] & ~inhibited;
    if (config_q[CF_INPUT])
    begin
      // register commands can never float
      cmd_a   = config_q[CF_SOFT_LEG_A_CMD];
      cmd_b   = config_q[CF_SOFT_LEG_B_CMD];
      a_float = 1'b0;
      b_float = 1'b0;
    end
    else
    begin
      cmd_a   = leg_cmd.a;
      cmd_b   = leg_cmd.b;
      a_float = leg_cmd.a_float;
      b_float = leg_cmd.b_float;
    end
    sc_a = status_q[ST_SCG1] | status_q[ST_SCP1];
    sc_b = status_q[ST_SCG2] | status_q[ST_SCP2];

    if (!hmode)
    begin
      drv_a = (cmd_a && !a_float) ? DRV_HIGH : DRV_LOW;
      drv_b = (cmd_b && !b_float) ? DRV_HIGH : DRV_LOW;
    end
    else if (b_float || !cmd_b)
    begin
      drv_a = DRV_HIGH;
      drv_b = DRV_HIGH;
    end
    else if (a_float)
    begin
      // b is high here, so leg a takes its inverse
      drv_a = DRV_LOW;
      drv_b = DRV_HIGH;
    end
    else if (cmd_a)
    begin
      drv_a = DRV_HIGH;
      drv_b = DRV_LOW;
    end
    else
    begin
      drv_a = DRV_LOW;
      drv_b = DRV_HIGH;
    end

    // half-bridge leaves overvoltage as a flag only
    ov_force = ov_act_q && hmode && !mask_q[MSK_DOV];
    if (ov_force)
    begin
      drv_a = DRV_HIGH;
      drv_b = DRV_HIGH;
    end

    if (!en_ok || uv_lock_q || status_q[ST_OT])
    begin
      drv_a = DRV_OFF;
      drv_b = DRV_OFF;
    end
    else if (hmode && (sc_a || sc_b))
    begin
      drv_a = DRV_OFF;
      drv_b = DRV_OFF;
    end
    else
    begin
      if (sc_a)
        drv_a = DRV_OFF;
      if (sc_b)
        drv_b = DRV_OFF;
    end

    case (drv_a)
      DRV_HIGH: leg_a_d = '{hs_on: 1'b1, ls_on: 1'b0};
      DRV_LOW:  leg_a_d = '{hs_on: 1'b0, ls_on: 1'b1};
      default:  leg_a_d = '{hs_on: 1'b0, ls_on: 1'b0};
    endcase
    case (drv_b)
      DRV_HIGH: leg_b_d = '{hs_on: 1'b1, ls_on: 1'b0};
      DRV_LOW:  leg_b_d = '{hs_on: 1'b0, ls_on: 1'b1};
      default:  leg_b_d = '{hs_on: 1'b0, ls_on: 1'b0};
    endcase

    // inhibit only reports while awake; asleep the pin follows the masked status bits alone
    fsn_d = ~((|(status_q & mask_q)) | (wake_pin & inhibited));
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bridge_leg_a   <= '0;
      bridge_leg_b   <= '0;
      fault_status_n <= 1'b1;
    end
    else
    begin
      bridge_leg_a   <= leg_a_d;
      bridge_leg_b   <= leg_b_d;
      fault_status_n <= fsn_d;
    end
  end

endmodule

//--- common/bfs_pkg.sv
package bfs_pkg;

  // clock and filter times
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_UV_FILT_NS  = 10000;
  localparam int unsigned T_OV_FILT_NS  = 3000;
  localparam int unsigned T_OT_FILT_NS  = 11000;
  localparam int unsigned CNT_W         = 7;
  // longest times round down
  localparam logic [CNT_W-1:0] UV_FILT_CYC =
    CNT_W'(T_UV_FILT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OV_FILT_CYC =
    CNT_W'(T_OV_FILT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OT_FILT_CYC =
    CNT_W'(T_OT_FILT_NS / CLK_PERIOD_NS);

  // filter channel indices
  localparam int unsigned FLT_UV    = 0;
  localparam int unsigned FLT_UVREC = 1;
  localparam int unsigned FLT_OV    = 2;
  localparam int unsigned FLT_OT    = 3;
  localparam int unsigned N_FLT     = 4;

  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_CLEAR  = 8'h0C;

  // status / mask bit positions
  localparam int unsigned ST_OT   = 0;
  localparam int unsigned ST_TW   = 1;
  localparam int unsigned ST_SCG1 = 4;
  localparam int unsigned ST_SCG2 = 5;
  localparam int unsigned ST_SCP1 = 6;
  localparam int unsigned ST_SCP2 = 7;
  localparam int unsigned ST_OV   = 8;
  localparam int unsigned ST_UV   = 9;
  localparam int unsigned MSK_DOV = 12;
  localparam int unsigned ST_W    = 16;

  // config bit positions
  localparam int unsigned CF_SOFT_LEG_A_CMD  = 0;
  localparam int unsigned CF_SOFT_LEG_B_CMD  = 1;
  localparam int unsigned CF_INPUT = 2;
  localparam int unsigned CF_MODE  = 3;
  localparam int unsigned CF_EN    = 4;

  localparam logic [15:0] MASK_RST   = 16'h46F1;
  localparam logic [15:0] CONFIG_RST = 16'h6D98;
  localparam logic [15:0] MASK_WR    = 16'h1FFF;
  localparam logic [15:0] CONFIG_WR  = 16'h1FFF;
  localparam logic [15:0] STATUS_W1C = 16'h03F1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // comparator inputs from the analog side
  typedef struct packed {
    logic       uv;       // supply below falling threshold
    logic       uv_rec;   // supply above threshold plus hysteresis
    logic       ov;       // overvoltage, hysteretic
    logic       tw;       // temperature warning, hysteretic
    logic       ot;       // overtemperature
    logic       ot_hys;   // still above ot threshold minus hysteresis
    logic [3:0] sc;       // {scp2, scp1, scg2, scg1}
  } bfs_cmp_t;

  typedef struct packed {
    logic a;
    logic a_float;
    logic b;
    logic b_float;
  } bfs_cmd_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } bfs_leg_t;

  typedef enum logic [1:0] {DRV_OFF, DRV_LOW, DRV_HIGH} bfs_drv_t;

endpackage

//--- tb/bfs_supervisor_checker.sv
`timescale 1ns/1ps
module bfs_supervisor_checker
  import bfs_pkg::*;
(
  input wire logic              hclk,          // clock
  input wire logic              hresetn,       // reset
  input wire logic              hsel,          // select
  input wire logic              hready,        // bus ready
  input wire logic [1:0]        htrans,        // transfer
  input wire logic              hwrite,        // write
  input wire logic              hreadyout,     // slave ready
  input wire logic [31:0]       hrdata,        // read data
  input wire logic              hresp,         // response
  input wire bfs_pkg::bfs_cmp_t cmp_in,        // comparators
  input wire logic              wake_pin,      // wake
  input wire logic              inhibit_pin,   // inhibit
  input wire logic              inhibit_float, // inhibit open
  input wire bfs_pkg::bfs_leg_t bridge_leg_a,  // leg a
  input wire bfs_pkg::bfs_leg_t bridge_leg_b,  // leg b
  input wire logic              fault_status_n // status
);
  logic [6:0] uv_q, uv_d, ot_q, ot_d;
  logic       off;

  // counters stand in for repetitions too long to unroll
  always_comb
  begin
    uv_d = !cmp_in.uv ? 7'h0 : (&uv_q ? uv_q : uv_q + 7'h1);
    ot_d = !cmp_in.ot ? 7'h0 : (&ot_q ? ot_q : ot_q + 7'h1);
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      uv_q <= 7'h0;
      ot_q <= 7'h0;
    end
    else
    begin
      uv_q <= uv_d;
      ot_q <= ot_d;
    end

  assign off = ({bridge_leg_a, bridge_leg_b} == 4'h0);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ready_ok_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_idle_a: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data left standing");
  inhib_off_a: assert property (
    (wake_pin && inhibit_pin) [*4] |-> off && !fault_status_n)
    else $error("inhibit did not tri-state");
  float_off_a: assert property (
    (wake_pin && inhibit_float) [*4] |-> off && !fault_status_n)
    else $error("open inhibit did not tri-state");
  sleep_off_a: assert property ((!wake_pin) [*4] |-> off)
    else $error("legs driven while asleep");
  uv_off_a: assert property (uv_q >= 7'd110 |-> off)
    else $error("undervoltage did not switch off");
  ot_off_a: assert property (ot_q >= 7'd118 |-> off)
    else $error("overtemperature did not switch off");
  sc_off_a: assert property (
    cmp_in.sc[0] [*6] |-> bridge_leg_a == 2'h0)
    else $error("short did not shut leg a");

  cover property (uv_q == 7'd110);
  cover property (ot_q == 7'd118 && off);
  cover property (wake_pin && inhibit_float && off);
endmodule

bind bfs_supervisor bfs_supervisor_checker u_chk (.hclk, .hresetn,
  .hsel, .hready, .htrans, .hwrite, .hreadyout, .hrdata, .hresp,
  .cmp_in, .wake_pin, .inhibit_pin, .inhibit_float, .bridge_leg_a,
  .bridge_leg_b, .fault_status_n);

//--- tb/bfs_host.sv
`timescale 1ns/1ps
module bfs_host
  import bfs_pkg::*;
(
  input  wire logic         hclk,         // clock
  input  wire logic         hreadyout,    // slave ready
  input  wire logic [31:0]  hrdata,       // read data
  output logic              hsel,         // select
  output logic      [31:0]  haddr,        // address
  output logic      [1:0]   htrans,       // transfer
  output logic              hwrite,       // write
  output logic      [31:0]  hwdata,       // write data
  output bfs_pkg::bfs_cmd_t leg_cmd,      // command pins
  output logic              wake_pin,     // wake
  output logic              inhibit_pin,  // inhibit
  output logic              inhibit_float // inhibit open
);
  initial
  begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {leg_cmd, inhibit_pin, inhibit_float} = '0;
    wake_pin = 1'b1;
  end

  task automatic pins(logic w, logic i, logic f, logic [3:0] c);
    @(posedge hclk);
    wake_pin <= w;
    inhibit_pin <= i;
    inhibit_float <= f;
    leg_cmd <= c;
  endtask

  task automatic xfer(logic w, logic [7:0] a, logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    // address phase carries inverted old data, so an early write sample is caught
    hwdata <= ~hwdata;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
endmodule

//--- tb/bfs_supervisor_tb.sv
`timescale 1ns/1ps
module bfs_supervisor_tb;
  import bfs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  bfs_cmp_t    cmp;
  bfs_cmd_t    leg_cmd;
  logic        wake_pin, inhibit_pin, inhibit_float, fault_status_n;
  bfs_leg_t    bridge_leg_a, bridge_leg_b;
  int          fails, cmp_count, cyc;

  bfs_supervisor u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout,
    .hrdata, .hresp, .cmp_in(cmp), .leg_cmd, .wake_pin, .inhibit_pin,
    .inhibit_float, .bridge_leg_a, .bridge_leg_b, .fault_status_n);
  bfs_host u_host (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .leg_cmd, .wake_pin, .inhibit_pin, .inhibit_float);

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge hclk);
    #10;
  endtask

  task automatic chk_out(logic [3:0] l, logic f);
    chk(32'({bridge_leg_a, bridge_leg_b}), 32'(l));
    chk(32'(fault_status_n), 32'(f));
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    u_host.xfer(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    logic [31:0] d;
    u_host.xfer(1'b1, a, v, d);
    wt(2);
  endtask

  task automatic setc(logic [9:0] v);
    @(posedge hclk);
    cmp <= v;
  endtask

  task automatic mode(logic h, logic [3:0] c);
    wr(REG_CONFIG, 32'h6D90 | 32'({h, 3'h0}));
    u_host.pins(1'b1, 1'b0, 1'b0, c);
    wt(4);
  endtask

  // legs packed as {a.hs, a.ls, b.hs, b.ls}
  function automatic logic [3:0] exp_legs(logic h, logic a, logic af,
                                          logic b, logic bf);
    logic av;
    logic bv;
    av = a & ~af;
    bv = b & ~bf;
    if (!h)
      return {av, ~av, bv, ~bv};
    if (!bv)
      return 4'hA;
    if (af)
      return 4'h6;
    return av ? 4'h9 : 4'h6;
  endfunction

  task automatic s_reg;
    chk_out(4'hA, 1'b1);
    rd(REG_MASK, 32'h46F1);
    rd(REG_CONFIG, 32'h6D98);
    rd(REG_STATUS, 32'h0);
    rd(8'h10, 32'h0);
    wr(REG_MASK, 32'hFFFFFFFF);
    rd(REG_MASK, 32'h5FFF);
    wr(REG_MASK, 32'h46F1);
  endtask

  task automatic s_truth;
    logic [3:0] e;
    for (int m = 0; m < 2; m++)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mode(m[0], 4'(i));
        e = exp_legs(m[0], i[3], i[2], i[1], i[0]);
        chk_out(e, 1'b1);
      end
      for (int i = 0; i < 4; i++)
      begin
        wr(REG_CONFIG, 32'h6D94 | 32'({m[0], 1'b0, i[1:0]}));
        chk_out(exp_legs(m[0], i[0], 1'b0, i[1], 1'b0), 1'b1);
      end
    end
  endtask

  task automatic s_ctl;
    mode(1'b1, 4'hA);
    u_host.pins(1'b1, 1'b1, 1'b0, 4'hA);
    wt(5);
    chk_out(4'h0, 1'b0);
    u_host.pins(1'b1, 1'b0, 1'b1, 4'hA);
    wt(5);
    chk_out(4'h0, 1'b0);
    u_host.pins(1'b0, 1'b0, 1'b0, 4'hA);
    wt(5);
    chk_out(4'h0, 1'b1);
    mode(1'b1, 4'hA);
    wr(REG_CONFIG, 32'h6D88);
    chk_out(4'h0, 1'b1);
  endtask

  task automatic s_uv;
    mode(1'b1, 4'hA);
    setc(10'h200);
    wt(90);
    setc(10'h100);
    wt(20);
    chk_out(4'h9, 1'b1);
    setc(10'h200);
    wt(20);
    chk_out(4'h9, 1'b1);
    wt(95);
    chk_out(4'h0, 1'b0);
    rd(REG_STATUS, 32'h200);
    setc(10'h100);
    wt(60);
    chk_out(4'h0, 1'b0);
    wt(60);
    chk_out(4'h9, 1'b0);
    wr(REG_CLEAR, 32'h200);
    chk_out(4'h9, 1'b1);
  endtask

  // one overvoltage pulse per call, status cleared afterwards
  task automatic ov_run(logic [3:0] l, logic f);
    setc(10'h180);
    wt(40);
    chk_out(l, f);
    rd(REG_STATUS, 32'h100);
    setc(10'h100);
    wt(5);
    chk_out(4'h9, f);
    wr(REG_CLEAR, 32'h100);
    chk_out(4'h9, 1'b1);
  endtask

  task automatic s_ov;
    mode(1'b1, 4'hA);
    ov_run(4'hA, 1'b1);
    wr(REG_MASK, 32'h47F1);
    ov_run(4'hA, 1'b0);
    mode(1'b0, 4'h8);
    ov_run(4'h9, 1'b0);
    wr(REG_MASK, 32'h57F1);
    mode(1'b1, 4'hA);
    ov_run(4'h9, 1'b0);
    wr(REG_MASK, 32'h46F1);
  endtask

  task automatic s_temp;
    mode(1'b1, 4'hA);
    setc(10'h140);
    wt(6);
    chk_out(4'h9, 1'b1);
    rd(REG_STATUS, 32'h2);
    setc(10'h100);
    wt(5);
    rd(REG_STATUS, 32'h0);
    setc(10'h130);
    wt(125);
    chk_out(4'h0, 1'b0);
    setc(10'h110);
    wt(5);
    wr(REG_CLEAR, 32'h1);
    rd(REG_STATUS, 32'h1);
    setc(10'h100);
    wt(5);
    wr(REG_CLEAR, 32'h1);
    chk_out(4'h9, 1'b1);
  endtask

  task automatic s_sc;
    mode(1'b1, 4'hA);
    setc(10'h101);
    wt(6);
    setc(10'h100);
    wt(3);
    chk_out(4'h0, 1'b0);
    u_host.pins(1'b0, 1'b0, 1'b0, 4'hA);
    mode(1'b1, 4'hA);
    chk_out(4'h9, 1'b1);
    mode(1'b0, 4'hA);
    setc(10'h101);
    wt(6);
    setc(10'h100);
    wt(3);
    chk_out(4'h2, 1'b0);
    u_host.pins(1'b1, 1'b1, 1'b0, 4'hA);
    u_host.pins(1'b1, 1'b0, 1'b0, 4'hA);
    wt(5);
    chk_out(4'hA, 1'b1);
    setc(10'h108);
    wt(6);
    setc(10'h100);
    wt(3);
    chk_out(4'h8, 1'b0);
    rd(REG_STATUS, 32'h80);
    wr(REG_CLEAR, 32'h80);
    chk_out(4'hA, 1'b1);
  endtask

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    hresetn = 1'b0;
    cmp = 10'h100;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wt(3);
    s_reg();
    s_truth();
    s_ctl();
    s_uv();
    s_ov();
    s_temp();
    s_sc();
    close_out();
  end
endmodule
